// File: design/mtop_pkg.sv
// package for the masked timed output port
package mtop_pkg;
  localparam int unsigned PIN_COUNT = 12;
  localparam int unsigned HOLD_W = 16;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_UNIT_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * HOLD_UNIT_S;
  localparam int unsigned PRE_W = 24;
  localparam logic [PIN_COUNT-1:0] PINS_RESET = 12'h000;
  localparam logic [HOLD_W-1:0] HOLD_ZERO = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_ONE = 16'h0001;

  typedef logic [PIN_COUNT-1:0] mtop_pins_t;

  typedef struct packed {
    mtop_pins_t lineMask;
    logic level;
    logic holdValid;
    logic [HOLD_W-1:0] holdSeconds;
  } mtop_cmd_s;
endpackage

// File: design/mtop_masked_output.sv
// masked output port with optional timed reversal per pin
`timescale 1ns/1ps
module mtop_masked_output
  import mtop_pkg::*;
#(
  parameter int unsigned TickCycles = TICK_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire mtop_cmd_s cmdIn,
  output logic cmdReady,
  output mtop_pins_t pinOut,
  output mtop_pins_t holdActive
);

  typedef enum logic {
    PIN_STEADY,
    PIN_TIMED
  } mtop_mode_e;

  // the tick rate is a parameter so that a bench can run the same logic fast
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TickCycles - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = PRE_W'(0);
  localparam logic [PRE_W-1:0] PRE_STEP = PRE_W'(1);

  logic cmdTaken;
  logic secTick;
  logic [PRE_W-1:0] preCount_q;
  logic [PRE_W-1:0] preCount_d;

  mtop_pins_t cmdMask;
  logic cmdLevel;
  logic [HOLD_W-1:0] cmdHold;
  mtop_mode_e cmdMode;

  mtop_pins_t pins_q;
  wire mtop_pins_t holdPending;
  logic [HOLD_W-1:0] remain_q [PIN_COUNT];

  // the strobe qualified by the mask bit of pin idx; bit 0 is pin 1
  function automatic logic pin_selected(
    input logic strobe,
    input mtop_pins_t mask,
    input int unsigned idx
  );
    logic hit;
    hit = strobe && mask[idx];
    return hit;
  endfunction

  // zero seconds with a hold asked for acts as a continuous level
  function automatic logic hold_armed(
    input mtop_cmd_s cmd
  );
    logic armed;
    armed = cmd.holdValid && (cmd.holdSeconds != HOLD_ZERO);
    return armed;
  endfunction

  // mode a selected pin enters after a command
  function automatic mtop_mode_e mode_after(
    input mtop_cmd_s cmd
  );
    mtop_mode_e mode;
    mode = hold_armed(cmd) ? PIN_TIMED : PIN_STEADY;
    return mode;
  endfunction

  // true on the tick that ends a hold
  function automatic logic hold_last(
    input logic [HOLD_W-1:0] remain
  );
    logic last;
    last = (remain == HOLD_ONE);
    return last;
  endfunction

  // one second less of a hold
  function automatic logic [HOLD_W-1:0] hold_step(
    input logic [HOLD_W-1:0] remain
  );
    logic [HOLD_W-1:0] next;
    next = remain - HOLD_ONE;
    return next;
  endfunction

  // last count of the prescaler, where the one-second tick fires
  function automatic logic pre_wrapped(
    input logic [PRE_W-1:0] count
  );
    logic wrapped;
    wrapped = (count == PRE_LAST);
    return wrapped;
  endfunction

  // commands are taken every cycle, so no queue is needed
  assign cmdReady = 1'b1;
  assign cmdTaken = cmdValid && cmdReady;
  assign pinOut = pins_q;
  assign holdActive = holdPending;

  // command fields pulled out once and shared by every pin
  assign cmdMask = cmdIn.lineMask;
  assign cmdLevel = cmdIn.level;
  assign cmdHold = cmdIn.holdSeconds;
  assign cmdMode = mode_after(cmdIn);

  // free running, so the first second of a hold may be short by up to TickCycles - 1 clock cycles
  always_comb begin
    preCount_d = preCount_q + PRE_STEP;
    if (pre_wrapped(preCount_q)) begin
      preCount_d = PRE_ZERO;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      preCount_q <= PRE_ZERO;
    end else begin
      preCount_q <= preCount_d;
    end
  end

  assign secTick = pre_wrapped(preCount_q);

  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic sel;
      logic last;
      mtop_mode_e mode_q;
      mtop_mode_e mode_d;
      logic level_d;
      logic [HOLD_W-1:0] remain_d;

      assign sel = pin_selected(cmdTaken, cmdMask, i);
      assign last = secTick && hold_last(remain_q[i]);
      assign holdPending[i] = (mode_q == PIN_TIMED);

      // a command on the edge of a reversal wins, so a fresh level is never lost
      always_comb begin
        mode_d = mode_q;
        case (mode_q)
          PIN_STEADY: begin
            if (sel) begin
              mode_d = cmdMode;
            end
          end
          PIN_TIMED: begin
            if (sel) begin
              mode_d = cmdMode;
            end else if (last) begin
              mode_d = PIN_STEADY;
            end
          end
          default: begin
            mode_d = PIN_STEADY;
          end
        endcase
      end

      always_comb begin
        level_d = pins_q[i];
        case (mode_q)
          PIN_STEADY: begin
            if (sel) begin
              level_d = cmdLevel;
            end
          end
          PIN_TIMED: begin
            if (sel) begin
              level_d = cmdLevel;
            end else if (last) begin
              level_d = ~pins_q[i];
            end
          end
          default: begin
            level_d = pins_q[i];
          end
        endcase
      end

      always_comb begin
        remain_d = remain_q[i];
        case (mode_q)
          PIN_STEADY: begin
            if (sel) begin
              remain_d = cmdHold;
            end
          end
          PIN_TIMED: begin
            if (sel) begin
              remain_d = cmdHold;
            end else if (secTick) begin
              remain_d = hold_step(remain_q[i]);
            end
          end
          default: begin
            remain_d = HOLD_ZERO;
          end
        endcase
      end

      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          pins_q[i] <= PINS_RESET[i];
        end else begin
          pins_q[i] <= level_d;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          mode_q <= PIN_STEADY;
        end else begin
          mode_q <= mode_d;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          remain_q[i] <= HOLD_ZERO;
        end else begin
          remain_q[i] <= remain_d;
        end
      end
    end
  endgenerate
endmodule

// File: testbench/mtop_properties.sv
// checker for the masked output port
`timescale 1ns/1ps
module mtop_properties import mtop_pkg::*; (input wire logic sys_clk, input wire logic nrst,
  input wire logic cmdValid, input wire mtop_cmd_s cmdIn, input wire logic cmdReady,
  input wire mtop_pins_t pinOut, input wire mtop_pins_t holdActive);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_set; cmdValid |=> !((pinOut ^ {12{$past(cmdIn.level)}}) & $past(cmdIn.lineMask));
  endproperty
  property p_keep; 1 |=> !((pinOut ^ $past(pinOut)) & ~$past(holdActive)
    & ~($past(cmdValid) ? $past(cmdIn.lineMask) : 12'h000)); endproperty
  property p_rev; !cmdValid |=> !($past(holdActive) & ~holdActive & ~(pinOut ^ $past(pinOut)));
  endproperty
  property p_cont; cmdValid && !cmdIn.holdValid |=> !(holdActive & $past(cmdIn.lineMask));
  endproperty
  property p_ready; cmdReady; endproperty
  property p_arm; cmdValid && cmdIn.holdValid && (cmdIn.holdSeconds != 16'h0000)
    |=> ((holdActive & $past(cmdIn.lineMask)) == $past(cmdIn.lineMask)); endproperty
  property p_zero; cmdValid && (cmdIn.holdSeconds == 16'h0000)
    |=> !(holdActive & $past(cmdIn.lineMask)); endproperty
  a_set: assert property (p_set) else $error("bad level");
  a_keep: assert property (p_keep) else $error("pin disturbed");
  a_rev: assert property (p_rev) else $error("no flip");
  a_cont: assert property (p_cont) else $error("hold set");
  a_ready: assert property (p_ready) else $error("not ready");
  a_arm: assert property (p_arm) else $error("hold not armed");
  a_zero: assert property (p_zero) else $error("zero hold armed");
  c_hold: cover property (cmdValid && cmdIn.holdValid);
  c_rev: cover property (!cmdValid && (holdActive != 12'h000) ##1 (holdActive == 12'h000));
  c_replace: cover property (cmdValid && ((cmdIn.lineMask & holdActive) != 12'h000));
  c_cont: cover property (cmdValid && !cmdIn.holdValid);
endmodule
bind mtop_masked_output mtop_properties chk(.sys_clk, .nrst, .cmdValid, .cmdIn, .cmdReady,
  .pinOut, .holdActive);

// File: testbench/mtop_equipment.sv
// equipment load on the pins; it only listens
`timescale 1ns/1ps
module mtop_equipment import mtop_pkg::*; (input wire mtop_pins_t pinIn);
endmodule

// File: testbench/mtop_masked_output_bench.sv
// bench for the masked output port
`timescale 1ns/1ps
module mtop_masked_output_bench import mtop_pkg::*;;
  // short tick so that timed reversals fall inside the run
  localparam int unsigned BENCH_TICK = 10;
  logic sys_clk = 0, nrst = 0, cmdValid = 0, cmdReady;
  mtop_cmd_s cmdIn = '0;
  mtop_pins_t pinOut, holdActive;
  int miscompares = 0, checked = 0;
  // rows: mask, level, holdValid, seconds, pins, pending
  logic [53:0] tbl [7] = '{{12'h8D6, 18'h20000, 24'h8D6000}, {12'h029, 18'h20000, 24'h8FF000},
    {12'h0F0, 18'h00000, 24'h80F000}, {12'h000, 18'h20000, 24'h80F000},
    {12'hFFF, 18'h20000, 24'hFFF000}, {12'h00F, 18'h10005, 24'hFF000F},
    {12'h003, 18'h30000, 24'hFF300C}};
  always #50 sys_clk = ~sys_clk;
  mtop_masked_output #(.TickCycles(BENCH_TICK)) dut(.sys_clk, .nrst, .cmdValid, .cmdIn,
    .cmdReady, .pinOut, .holdActive);
  mtop_equipment eq(.pinIn(pinOut));
  task cmp(string n, mtop_pins_t e, mtop_pins_t a);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, a);
    end
  endtask
  task cmp_ready(string n, logic e, logic a);
    checked++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, a);
    end
  endtask
  // one-cycle strobe; callers let an edge pass before the next one
  task automatic issue(input mtop_pins_t m, input logic lv, input logic hv,
    input logic [HOLD_W-1:0] s);
    cmdIn = '{lineMask: m, level: lv, holdValid: hv, holdSeconds: s};
    cmdValid = 1'b1;
    @(negedge sys_clk);
    cmdValid = 1'b0;
  endtask
  task finish_test;
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    finish_test;
  end
  // back to back strobes; the ten cycle bench tick brings timed reversals inside the run
  initial begin
    repeat (2) @(negedge sys_clk);
    nrst = 1;
    @(negedge sys_clk);
    cmdValid = 1;
    foreach (tbl[i]) begin
      cmdIn = tbl[i][53:24];
      @(negedge sys_clk);
      cmp("pinOut", tbl[i][23:12], pinOut);
      cmp("holdActive", tbl[i][11:0], holdActive);
    end
    cmdValid = 0;
    cmp_ready("cmdReady", 1'b1, cmdReady);
    repeat (30) @(negedge sys_clk);
    cmp("pinOut", 12'hFF3, pinOut);
    cmp("holdActive", 12'h00C, holdActive);
    repeat (30) @(negedge sys_clk);
    cmp("pinOut", 12'hFFF, pinOut);
    cmp("holdActive", 12'h000, holdActive);
    issue(12'h001, 1'b1, 1'b1, 16'h0003);
    cmp("holdActive", 12'h001, holdActive);
    @(negedge sys_clk);
    issue(12'h001, 1'b0, 1'b0, 16'h0000);
    cmp("holdActive", 12'h000, holdActive);
    repeat (50) @(negedge sys_clk);
    cmp("pinOut", 12'hFFE, pinOut);
    issue(12'h0F0, 1'b0, 1'b1, 16'h0009);
    cmp("holdActive", 12'h0F0, holdActive);
    cmp("pinOut", 12'hF0E, pinOut);
    nrst = 0;
    repeat (2) @(negedge sys_clk);
    cmp("pinOut", PINS_RESET, pinOut);
    cmp("holdActive", 12'h000, holdActive);
    nrst = 1;
    issue(12'h8D6, 1'b1, 1'b1, 16'h000A);
    cmp("pinOut", 12'h8D6, pinOut);
    cmp("holdActive", 12'h8D6, holdActive);
    repeat (85) @(negedge sys_clk);
    cmp("pinOut", 12'h8D6, pinOut);
    repeat (30) @(negedge sys_clk);
    cmp("pinOut", 12'h000, pinOut);
    cmp("holdActive", 12'h000, holdActive);
    finish_test;
  end
endmodule
